// [verilog/dfl_pkg.sv]
// Constants for the drive fault latch and encoder.
// Assumes one 125 MHz core clock shared by every design file.
package dfl_pkg;
  localparam int CLK_MHZ = 125;
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_OC_RUN = 8'h01;
  localparam logic [7:0] CODE_OC_DEC = 8'h02;
  localparam logic [7:0] CODE_OC_ACC = 8'h03;
  localparam logic [7:0] CODE_OC_STOP = 8'h04;
  localparam logic [7:0] CODE_OVERLOAD = 8'h05;
  localparam logic [7:0] CODE_BRAKE = 8'h06;
  localparam logic [7:0] CODE_REGEN_OV = 8'h07;
  localparam logic [7:0] CODE_PROG_MEM = 8'h08;
  localparam logic [7:0] CODE_UNDERVOLT = 8'h09;
  localparam logic [7:0] CODE_CPU1 = 8'h11;
  localparam logic [7:0] CODE_EXT = 8'h12;
  localparam logic [7:0] CODE_RESTART = 8'h13;
  localparam logic [7:0] CODE_GROUND = 8'h14;
  localparam logic [7:0] CODE_MAINS_OV = 8'h15;
  localparam logic [7:0] CODE_OVERTEMP = 8'h21;
  localparam logic [7:0] CODE_CPU2 = 8'h22;
  localparam logic [7:0] CODE_GATE_ARRAY = 8'h23;
  localparam logic [7:0] CODE_THERMISTOR = 8'h35;
  localparam logic [7:0] CODE_COMM = 8'h60;
  localparam logic [7:0] CODE_BLINK = 8'h88;
  localparam int NUM_SRC = 19;
  // Mains overvoltage shutdown delay
  localparam int MAINS_OV_DELAY_S = 100;
  localparam longint MAINS_OV_CYCLES = longint'(MAINS_OV_DELAY_S) * CLK_MHZ * 1000000;
  // Brief display of the blink pattern
  localparam int BLINK_MS = 500;
  localparam longint BLINK_CYCLES = longint'(BLINK_MS) * CLK_MHZ * 1000;
  localparam logic [1:0] ACK_RISE_STOP = 2'h0;
  localparam logic [1:0] ACK_FALL_STOP = 2'h1;
  localparam logic [1:0] ACK_RISE_ONLY = 2'h2;
  typedef enum logic [2:0] {
    DFL_IDLE = 3'h1,
    DFL_FAULT = 3'h2,
    DFL_BLINK = 3'h4
  } dfl_state_type;
endpackage

// [verilog/dfl_sync.sv]
// Two flip-flop synchroniser for one asynchronous level.
// Assumes the input is unrelated to clk_in.
`timescale 1ns/1ps
module dfl_sync (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic d_in,
  output logic q_out
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;
  always_comb begin
    meta_next = d_in;
    sync_next = meta_reg;
  end
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end
  assign q_out = sync_reg;
endmodule // dfl_sync

// [verilog/dfl_timer.sv]
// Down counter that raises done after a loaded number of cycles.
// Assumes start is a one-cycle pulse from the same clock.
`timescale 1ns/1ps
module dfl_timer #(
  parameter int WIDTH = 40
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic start_in,
  input wire logic clear_in,
  input wire logic [WIDTH-1:0] load_in,
  output logic busy_out,
  output logic done_out
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic busy_reg;
  logic busy_next;
  logic done_reg;
  logic done_next;
  always_comb begin
    count_next = count_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (clear_in) begin
      busy_next = 1'b0;
    end else if (start_in) begin
      count_next = load_in;
      busy_next = 1'b1;
    end else if (busy_reg) begin
      if (count_reg <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end else begin
        count_next = count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      count_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end
  assign busy_out = busy_reg;
  assign done_out = done_reg;
endmodule // dfl_timer

// [verilog/dfl_top.sv]
// Fault latch and code encoder for a motor drive power stage.
// Assumes monitors on core_clk_in; pins pass through synchronisers here.
//
// Function
// R1: Any detected fault inhibits the power output so the motor coasts.
// R2: Fault lamp is on while a fault is latched.
// R3: Numeric code of latched fault is presented to an attached keypad.
// R4: Inhibit holds until acknowledged, even after the cause has gone.
// R5: Acknowledge by keypad stop key, acknowledge input, or power cycle.
// R6: Overcurrent codes 01 run, 02 decel, 03 accel, 04 standstill.
// R7: Motor overload protection trip latches code 05.
// R8: Excessive brake duty turns brake transistor off and latches code 06; code does so only if present when a fault latches.
// R9: Regenerative overvoltage latches code 07.
// R10: Internal DC undervoltage latches code 09.
// R11: Processor faults latch code 11, or 22 for the second supervisor.
// R12: Active external fault input latches code 12.
// R13: Power-up or supply return with restart guard active latches code 13.
// R14: Ground fault on any output phase latches code 14.
// R15: Mains overvoltage latches code 15 and shuts down about 100 s later; code starts the timer only on a latch from idle, not from blink.
// R16: Power stage overtemperature latches code 21.
// R17: Gate array link error latches code 23 and kills switching at once; code does so only if present when a fault latches.
// R18: External thermistor resistance too high latches code 35.
// R19: Serial supervision timeout latches code 60.
// R20: Brief undervoltage switches outputs off and shows 888 only briefly.
// R21: Program memory fault latches code 08.
// R22: Ack edge select: 00 rise clears and stops, 01 fall, 02 rise clears.
// R23: External fault stays latched after its input is released.
// R24: First latched fault code is kept until acknowledgement.
// R25: Acknowledge is ignored while the causing condition is still present.
`timescale 1ns/1ps
module dfl_top #(
  parameter longint MAINS_OV_CYCLES = dfl_pkg::MAINS_OV_CYCLES,
  parameter longint BLINK_CYCLES = dfl_pkg::BLINK_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic overcurrent_in,
  input wire logic accelerating_in,
  input wire logic decelerating_in,
  input wire logic standstill_in,
  input wire logic overload_trip_in,
  input wire logic brake_duty_excess_in,
  input wire logic regen_overvolt_in,
  input wire logic prog_mem_fault_in,
  input wire logic dc_undervolt_in,
  input wire logic cpu1_fault_in,
  input wire logic cpu2_fault_in,
  input wire logic ground_fault_in,
  input wire logic mains_overvolt_in,
  input wire logic overtemp_in,
  input wire logic gate_array_err_in,
  input wire logic comm_timeout_in,
  input wire logic brief_undervolt_in,
  input wire logic supply_return_in,
  input wire logic external_fault_input_in,
  input wire logic restart_guard_input_in,
  input wire logic thermistor_input_in,
  input wire logic ack_input_in,
  input wire logic keypad_present_in,
  input wire logic keypad_stop_in,
  input wire logic [1:0] ack_edge_select_in,
  output logic inhibit_out,
  output logic switching_kill_out,
  output logic brake_enable_out,
  output logic fault_lamp_out,
  output logic fault_latched_out,
  output logic [7:0] keypad_code_out,
  output logic keypad_code_valid_out,
  output logic stop_request_out,
  output logic mains_shutdown_out
);
  localparam int N = dfl_pkg::NUM_SRC;
  localparam int TW = 40;

  logic ext_s;
  logic guard_s;
  logic therm_s;
  logic ack_s;
  logic stop_s;

  dfl_sync u_sync_ext (.clk_in(core_clk_in), .nrst_in(nrst_in),
    .d_in(external_fault_input_in), .q_out(ext_s));
  dfl_sync u_sync_guard (.clk_in(core_clk_in), .nrst_in(nrst_in),
    .d_in(restart_guard_input_in), .q_out(guard_s));
  dfl_sync u_sync_therm (.clk_in(core_clk_in), .nrst_in(nrst_in),
    .d_in(thermistor_input_in), .q_out(therm_s));
  dfl_sync u_sync_ack (.clk_in(core_clk_in), .nrst_in(nrst_in),
    .d_in(ack_input_in), .q_out(ack_s));
  dfl_sync u_sync_stop (.clk_in(core_clk_in), .nrst_in(nrst_in),
    .d_in(keypad_stop_in), .q_out(stop_s));

  // Power-up marker: low until the guard synchroniser output has settled
  logic [2:0] powered_reg;
  logic [2:0] powered_next;
  logic ack_d_reg;
  logic ack_d_next;
  logic stop_d_reg;
  logic stop_d_next;

  // Fault condition vector, priority by index (lowest wins within one cycle)
  logic [N-1:0] cond;
  logic [7:0] codes [N];
  logic restart_cond;

  always_comb begin
    restart_cond = guard_s && (supply_return_in || !powered_reg[2]); // see R13
    cond[0] = gate_array_err_in; // see R17
    cond[1] = prog_mem_fault_in; // see R21
    cond[2] = cpu1_fault_in; // see R11
    cond[3] = cpu2_fault_in; // see R11
    cond[4] = ground_fault_in; // see R14
    cond[5] = overcurrent_in; // see R6
    cond[6] = regen_overvolt_in; // see R9
    cond[7] = mains_overvolt_in; // see R15
    cond[8] = overload_trip_in; // see R7
    cond[9] = brake_duty_excess_in; // see R8
    cond[10] = dc_undervolt_in; // see R10
    cond[11] = overtemp_in; // see R16
    cond[12] = therm_s; // see R18
    cond[13] = ext_s; // see R12
    cond[14] = restart_cond;
    cond[15] = comm_timeout_in; // see R19
    cond[16] = 1'b0;
    cond[17] = 1'b0;
    cond[18] = 1'b0;
  end

  always_comb begin
    codes[0] = dfl_pkg::CODE_GATE_ARRAY;
    codes[1] = dfl_pkg::CODE_PROG_MEM;
    codes[2] = dfl_pkg::CODE_CPU1;
    codes[3] = dfl_pkg::CODE_CPU2;
    codes[4] = dfl_pkg::CODE_GROUND;
    // Overcurrent code follows the operating state
    if (decelerating_in) begin
      codes[5] = dfl_pkg::CODE_OC_DEC; // see R6
    end else if (accelerating_in) begin
      codes[5] = dfl_pkg::CODE_OC_ACC; // see R6
    end else if (standstill_in) begin
      codes[5] = dfl_pkg::CODE_OC_STOP; // see R6
    end else begin
      codes[5] = dfl_pkg::CODE_OC_RUN; // see R6
    end
    codes[6] = dfl_pkg::CODE_REGEN_OV;
    codes[7] = dfl_pkg::CODE_MAINS_OV;
    codes[8] = dfl_pkg::CODE_OVERLOAD;
    codes[9] = dfl_pkg::CODE_BRAKE;
    codes[10] = dfl_pkg::CODE_UNDERVOLT;
    codes[11] = dfl_pkg::CODE_OVERTEMP;
    codes[12] = dfl_pkg::CODE_THERMISTOR;
    codes[13] = dfl_pkg::CODE_EXT;
    codes[14] = dfl_pkg::CODE_RESTART;
    codes[15] = dfl_pkg::CODE_COMM;
    codes[16] = dfl_pkg::CODE_NONE;
    codes[17] = dfl_pkg::CODE_NONE;
    codes[18] = dfl_pkg::CODE_NONE;
  end

  logic any_cond;
  logic [7:0] first_code;
  logic [4:0] first_idx;
  always_comb begin
    any_cond = |cond;
    first_code = dfl_pkg::CODE_NONE;
    first_idx = 5'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (cond[i]) begin
        first_code = codes[i];
        first_idx = 5'(i);
      end
    end
  end

  // Acknowledge edge detection
  logic ack_rise;
  logic ack_fall;
  logic stop_press;
  logic ack_event;
  logic ack_stops;
  always_comb begin
    ack_rise = ack_s && !ack_d_reg;
    ack_fall = !ack_s && ack_d_reg;
    stop_press = keypad_present_in && stop_s && !stop_d_reg;
    ack_stops = 1'b0;
    case (ack_edge_select_in) // see R22
      dfl_pkg::ACK_RISE_STOP: begin
        ack_event = ack_rise;
        ack_stops = ack_rise;
      end
      dfl_pkg::ACK_FALL_STOP: begin
        ack_event = ack_fall;
        ack_stops = ack_fall;
      end
      dfl_pkg::ACK_RISE_ONLY: begin
        ack_event = ack_rise;
      end
      default: begin
        ack_event = ack_rise;
        ack_stops = ack_rise;
      end
    endcase
    ack_event = ack_event || stop_press; // see R5
  end

  dfl_pkg::dfl_state_type state_reg;
  dfl_pkg::dfl_state_type state_next;
  logic [7:0] code_reg;
  logic [7:0] code_next;
  logic [4:0] idx_reg;
  logic [4:0] idx_next;
  logic stop_req_reg;
  logic stop_req_next;
  logic brake_off_reg;
  logic brake_off_next;
  logic kill_reg;
  logic kill_next;
  logic blink_start;
  logic blink_busy;
  logic ov_start;
  logic ov_done;
  logic shut_reg;
  logic shut_next;

  always_comb begin
    state_next = state_reg;
    code_next = code_reg;
    idx_next = idx_reg;
    stop_req_next = 1'b0;
    brake_off_next = brake_off_reg;
    kill_next = kill_reg;
    blink_start = 1'b0;
    powered_next = {powered_reg[1:0], 1'b1};
    ack_d_next = ack_s;
    stop_d_next = stop_s;
    shut_next = shut_reg || ov_done; // see R15
    case (state_reg)
      dfl_pkg::DFL_IDLE: begin
        if (any_cond) begin
          state_next = dfl_pkg::DFL_FAULT; // see R1
          code_next = first_code; // see R24
          idx_next = first_idx;
          brake_off_next = cond[9]; // see R8
          kill_next = cond[0]; // see R17
        end else if (brief_undervolt_in) begin
          state_next = dfl_pkg::DFL_BLINK; // see R20
          blink_start = 1'b1;
        end
      end
      dfl_pkg::DFL_FAULT: begin
        // Held regardless of cause; new causes do not overwrite code
        if (ack_event && !cond[idx_reg]) begin // see R4, R25, R23
          state_next = dfl_pkg::DFL_IDLE;
          code_next = dfl_pkg::CODE_NONE;
          brake_off_next = 1'b0;
          kill_next = 1'b0;
          shut_next = ov_done; // see R15
          stop_req_next = ack_stops || stop_press;
        end
      end
      dfl_pkg::DFL_BLINK: begin
        if (any_cond) begin
          state_next = dfl_pkg::DFL_FAULT;
          code_next = first_code;
          idx_next = first_idx;
          brake_off_next = cond[9];
          kill_next = cond[0];
        end else if (!blink_busy && !brief_undervolt_in) begin
          state_next = dfl_pkg::DFL_IDLE;
        end
      end
      default: begin
        state_next = dfl_pkg::DFL_FAULT;
        code_next = dfl_pkg::CODE_NONE;
      end
    endcase
  end

  assign ov_start = state_reg == dfl_pkg::DFL_IDLE && any_cond && first_idx == 5'h07;

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      state_reg <= dfl_pkg::DFL_IDLE;
      code_reg <= dfl_pkg::CODE_NONE;
      idx_reg <= 5'h00;
      stop_req_reg <= 1'b0;
      brake_off_reg <= 1'b0;
      kill_reg <= 1'b0;
      powered_reg <= 3'h0;
      ack_d_reg <= 1'b0;
      stop_d_reg <= 1'b0;
      shut_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      code_reg <= code_next;
      idx_reg <= idx_next;
      stop_req_reg <= stop_req_next;
      brake_off_reg <= brake_off_next;
      kill_reg <= kill_next;
      powered_reg <= powered_next;
      ack_d_reg <= ack_d_next;
      stop_d_reg <= stop_d_next;
      shut_reg <= shut_next;
    end
  end

  dfl_timer #(.WIDTH(TW)) u_blink (
    .clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .start_in(blink_start),
    .clear_in(1'b0),
    .load_in(TW'(BLINK_CYCLES)),
    .busy_out(blink_busy),
    .done_out()
  );

  dfl_timer #(.WIDTH(TW)) u_mains_ov (
    .clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .start_in(ov_start),
    .clear_in(state_reg == dfl_pkg::DFL_IDLE && !any_cond),
    .load_in(TW'(MAINS_OV_CYCLES)),
    .busy_out(),
    .done_out(ov_done)
  );

  logic faulted;
  assign faulted = state_reg == dfl_pkg::DFL_FAULT;
  assign inhibit_out = faulted || state_reg == dfl_pkg::DFL_BLINK; // see R1, R20
  assign switching_kill_out = kill_reg; // see R17
  assign brake_enable_out = !brake_off_reg; // see R8
  assign fault_lamp_out = faulted; // see R2
  assign fault_latched_out = faulted;
  assign keypad_code_out = state_reg == dfl_pkg::DFL_BLINK ? dfl_pkg::CODE_BLINK : code_reg;
  assign keypad_code_valid_out = keypad_present_in && !(state_reg == dfl_pkg::DFL_IDLE); // see R3
  assign stop_request_out = stop_req_reg;
  assign mains_shutdown_out = shut_reg; // see R15
endmodule // dfl_top

// [verification/dfl_top_asserts.sv]
// Concurrent checks on the fault latch and encoder ports.
// Assumes it is bound to dfl_top and shares its clock and reset.
`timescale 1ns/1ps
module dfl_top_checker (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic overcurrent_in,
  input wire logic decelerating_in,
  input wire logic ground_fault_in,
  input wire logic gate_array_err_in,
  input wire logic prog_mem_fault_in,
  input wire logic cpu1_fault_in,
  input wire logic cpu2_fault_in,
  input wire logic ack_input_in,
  input wire logic keypad_stop_in,
  input wire logic keypad_present_in,
  input wire logic inhibit_out,
  input wire logic switching_kill_out,
  input wire logic brake_enable_out,
  input wire logic fault_lamp_out,
  input wire logic fault_latched_out,
  input wire logic [7:0] keypad_code_out,
  input wire logic keypad_code_valid_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_quiet;
    !ack_input_in && !keypad_stop_in;
  endsequence
  sequence s_oc_dec;
    !inhibit_out && overcurrent_in && decelerating_in && !gate_array_err_in
      && !prog_mem_fault_in && !cpu1_fault_in && !cpu2_fault_in && !ground_fault_in;
  endsequence
  property p_inhibit;
    !inhibit_out && (overcurrent_in || ground_fault_in || gate_array_err_in) |=> inhibit_out;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("fault left output enabled");
  property p_lamp;
    (fault_lamp_out == fault_latched_out) && (!fault_latched_out || inhibit_out);
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp disagrees with latch");
  property p_valid;
    keypad_code_valid_out == (keypad_present_in && inhibit_out);
  endproperty
  a_valid: assert property (p_valid) else $error("keypad code valid wrong");
  property p_hold;
    s_quiet [*7] ##0 fault_latched_out |=> fault_latched_out;
  endproperty
  a_hold: assert property (p_hold) else $error("latch dropped unacknowledged");
  property p_oc_dec;
    s_oc_dec |=> keypad_code_out == 8'h02;
  endproperty
  a_oc_dec: assert property (p_oc_dec) else $error("decel overcurrent code wrong");
  property p_brake;
    !brake_enable_out |-> fault_latched_out && keypad_code_out == 8'h06;
  endproperty
  a_brake: assert property (p_brake) else $error("brake off without its fault");
  property p_kill;
    !inhibit_out && gate_array_err_in |=> switching_kill_out && keypad_code_out == 8'h23;
  endproperty
  a_kill: assert property (p_kill) else $error("gate array fault not handled");
  property p_first;
    fault_latched_out ##1 fault_latched_out |-> $stable(keypad_code_out);
  endproperty
  a_first: assert property (p_first) else $error("latched code changed");
  property p_refuse;
    fault_latched_out && ground_fault_in && keypad_code_out == 8'h14 |=> fault_latched_out;
  endproperty
  a_refuse: assert property (p_refuse) else $error("ack taken with cause present");
endmodule // dfl_top_checker

bind dfl_top dfl_top_checker chk_u (.core_clk_in, .nrst_in, .overcurrent_in, .decelerating_in,
  .ground_fault_in, .gate_array_err_in, .prog_mem_fault_in, .cpu1_fault_in, .cpu2_fault_in,
  .ack_input_in, .keypad_stop_in, .keypad_present_in, .inhibit_out, .switching_kill_out,
  .brake_enable_out, .fault_lamp_out, .fault_latched_out, .keypad_code_out,
  .keypad_code_valid_out);

// [verification/dfl_far_model.sv]
// Behavioural keypad and acknowledge push button for the fault latch.
// Assumes press requests arrive as one-cycle pulses set at the falling edge.
`timescale 1ns/1ps
module dfl_far_model #(
  parameter int HOLD = 4
) (
  input wire logic core_clk_in,
  input wire logic attach_in,
  input wire logic press_stop_in,
  input wire logic press_ack_in,
  output logic keypad_present_out,
  output logic keypad_stop_out,
  output logic ack_out
);
  int stop_cnt = 0;
  int ack_cnt = 0;
  // A press lasts HOLD cycles, as a hand on a key would
  always @(negedge core_clk_in) begin
    if (press_stop_in)
      stop_cnt <= HOLD;
    else if (stop_cnt > 0)
      stop_cnt <= stop_cnt - 1;
    if (press_ack_in)
      ack_cnt <= HOLD;
    else if (ack_cnt > 0)
      ack_cnt <= ack_cnt - 1;
  end
  assign keypad_present_out = attach_in;
  assign keypad_stop_out = attach_in && (stop_cnt > 0);
  assign ack_out = ack_cnt > 0;
endmodule // dfl_far_model

// [verification/tb_dfl_top.sv]
// Self-checking bench for the drive fault latch and encoder.
// Assumes dfl_top, the partner model and the checker bind are compiled first.
`timescale 1ns/1ps
module tb_dfl_top;
  logic core_clk_in, nrst_in, attach, pst, pak, stop_seen;
  logic [17:0] f;
  logic [1:0] op, ack_edge_select_in;
  logic keypad_present_in, keypad_stop_in, ack_input_in;
  logic inhibit_out, switching_kill_out, brake_enable_out, fault_lamp_out;
  logic fault_latched_out, keypad_code_valid_out, stop_request_out, mains_shutdown_out;
  logic [7:0] keypad_code_out;
  logic [19:0] r;
  int err_count = 0;
  int comparisons = 0;
  // Rows: source index, operating state, expected code
  logic [19:0] rows [18] = '{20'h00001, 20'h00102, 20'h00203, 20'h00304, 20'h01005,
    20'h02006, 20'h03007, 20'h04008, 20'h05009, 20'h06011, 20'h07012, 20'h08014,
    20'h09015, 20'h0A021, 20'h0B022, 20'h0C023, 20'h0D035, 20'h0E060};
  dfl_top #(.MAINS_OV_CYCLES(20), .BLINK_CYCLES(10)) dut_u (
    .core_clk_in, .nrst_in, .overcurrent_in(f[0]), .accelerating_in(op == 2'h2),
    .decelerating_in(op == 2'h1), .standstill_in(op == 2'h3),
    .overload_trip_in(f[1]), .brake_duty_excess_in(f[2]), .regen_overvolt_in(f[3]),
    .prog_mem_fault_in(f[4]), .dc_undervolt_in(f[5]), .cpu1_fault_in(f[6]),
    .external_fault_input_in(f[7]), .ground_fault_in(f[8]), .mains_overvolt_in(f[9]),
    .overtemp_in(f[10]), .cpu2_fault_in(f[11]), .gate_array_err_in(f[12]),
    .thermistor_input_in(f[13]), .comm_timeout_in(f[14]), .brief_undervolt_in(f[15]),
    .supply_return_in(f[16]), .restart_guard_input_in(f[17]), .ack_input_in,
    .keypad_present_in, .keypad_stop_in, .ack_edge_select_in, .inhibit_out,
    .switching_kill_out, .brake_enable_out, .fault_lamp_out, .fault_latched_out,
    .keypad_code_out, .keypad_code_valid_out, .stop_request_out, .mains_shutdown_out);
  dfl_far_model far_u (.core_clk_in, .attach_in(attach), .press_stop_in(pst),
    .press_ack_in(pak), .keypad_present_out(keypad_present_in),
    .keypad_stop_out(keypad_stop_in), .ack_out(ack_input_in));
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask
  task automatic ck(input logic l, input logic i, input logic [7:0] c);
    chk("lamp", {7'h00, l}, {7'h00, fault_lamp_out});
    chk("latched", {7'h00, l}, {7'h00, fault_latched_out});
    chk("inhibit", {7'h00, i}, {7'h00, inhibit_out});
    chk("valid", {7'h00, i & attach}, {7'h00, keypad_code_valid_out});
    chk("code", c, keypad_code_out);
  endtask
  task automatic ack(input logic k);
    if (k) pst <= 1'b1;
    else pak <= 1'b1;
    cyc(1);
    pst <= 1'b0;
    pak <= 1'b0;
    cyc(10);
  endtask
  task automatic pulse(input int b);
    f[b] <= 1'b1;
    cyc(1);
    f <= '0;
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in)
    if (stop_request_out === 1'b1) stop_seen <= 1'b1;
  initial begin
    repeat (5000) @(posedge core_clk_in);
    err_count++;
    results();
  end
  initial begin
    nrst_in = 1'b0;
    attach = 1'b1;
    pst = 1'b0;
    pak = 1'b0;
    stop_seen = 1'b0;
    f = '0;
    op = 2'h0;
    ack_edge_select_in = 2'h0;
    cyc(10);
    ck(1'b0, 1'b0, 8'h00);
    chk("brake", 8'h01, {7'h00, brake_enable_out});
    nrst_in <= 1'b1;
    cyc(2);
    for (int i = 0; i < 18; i++) begin
      r = rows[i];
      op <= r[9:8];
      pulse(int'(r[16:12]));
      cyc(8);
      ck(1'b1, 1'b1, r[7:0]);
      chk("brake", {7'h00, r[16:12] != 5'h02}, {7'h00, brake_enable_out});
      chk("kill", {7'h00, r[16:12] == 5'h0C}, {7'h00, switching_kill_out});
      op <= 2'h0;
      ack(r[12]);
      ck(1'b0, 1'b0, 8'h00);
    end
    // Two faults at once, then a third while latched
    f <= 18'h01001;
    cyc(1);
    f <= 18'h00100;
    cyc(3);
    f <= '0;
    cyc(2);
    ck(1'b1, 1'b1, 8'h23);
    ack(1'b1);
    // Acknowledge while the cause stays present
    f[8] <= 1'b1;
    cyc(2);
    ack(1'b0);
    ck(1'b1, 1'b1, 8'h14);
    f <= '0;
    cyc(1);
    ack(1'b0);
    ck(1'b0, 1'b0, 8'h00);
    for (int m = 0; m < 4; m++) begin
      ack_edge_select_in <= m[1:0];
      pulse(3);
      cyc(8);
      stop_seen = 1'b0;
      pak <= 1'b1;
      cyc(1);
      pak <= 1'b0;
      cyc(4);
      chk("held", {7'h00, m == 1}, {7'h00, fault_latched_out});
      cyc(8);
      ck(1'b0, 1'b0, 8'h00);
      chk("stop", {7'h00, m != 2}, {7'h00, stop_seen});
    end
    f[17] <= 1'b1;
    cyc(4);
    f[16] <= 1'b1;
    cyc(1);
    f <= '0;
    cyc(4);
    ck(1'b1, 1'b1, 8'h13);
    ack(1'b1);
    attach <= 1'b0;
    pulse(15);
    cyc(2);
    ck(1'b0, 1'b1, 8'h88);
    cyc(12);
    ck(1'b0, 1'b0, 8'h00);
    attach <= 1'b1;
    f[9] <= 1'b1;
    cyc(10);
    chk("shutdown", 8'h00, {7'h00, mains_shutdown_out});
    cyc(15);
    chk("shutdown", 8'h01, {7'h00, mains_shutdown_out});
    f <= '0;
    nrst_in <= 1'b0;
    cyc(3);
    nrst_in <= 1'b1;
    cyc(1);
    ck(1'b0, 1'b0, 8'h00);
    // Supply applied with the restart guard already active
    f[17] <= 1'b1;
    nrst_in <= 1'b0;
    cyc(3);
    nrst_in <= 1'b1;
    cyc(4);
    ck(1'b1, 1'b1, 8'h13);
    results();
  end
endmodule // tb_dfl_top
